// *** logic/fault_status_register.sv ***
`timescale 1ns/10ps
`include "fault_status_cfg.svh"

module fault_status_register
  import fault_status_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  output logic sdo,
  input wire logic status_on_write_enable,
  input wire logic user_toggle,
  input wire logic [`CHANNELS-1:0] boost_limit,
  input wire logic [`CHANNELS-1:0] iout_fault_in,
  input wire logic [`CHANNELS-1:0] ramp_active_in,
  input wire logic over_temp_in,
  input wire logic fault_n_in,
  output logic fault_n_out,
  output logic fault_oe,
  output logic [`STATUS_W-1:0] status_word,
  output logic packet_check_error_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and decode signals

  top_state_t s_q;
  top_state_t s_d;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_start;
  logic frame_stop;
  logic crc_clear;
  logic crc_bit_valid;
  logic crc_ok;
  logic [`STATUS_W-1:0] status_q;
  logic [`SHIFT_W-1:0] word_24;
  logic [`SHIFT_W-1:0] word_32;
  logic frame_short;
  logic frame_long;
  logic frame_full;
  logic is_status_read;
  logic pec_fail;
  logic status_consumed;
  logic fault_any;
  logic pin_seen_low;
  logic in_frame;
  logic frame_end;
  logic take_bit;
  logic emit_bit;
  logic status_next_frame;
  logic read_next;
  logic [`OUT_W-1:0] out_load;
  logic [`OUT_W-1:0] out_next;
  logic [`CNT_W-1:0] cnt_next;
  logic [`SHIFT_W-1:0] shift_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection on the serial pins
  // Pins are sampled directly; the host must meet setup to this clock

  assign sclk_fall = s_q.sclk & ~sclk;
  assign sclk_rise = ~s_q.sclk & sclk;
  assign frame_start = s_q.sync_n & ~sync_n;
  assign frame_stop = ~s_q.sync_n & sync_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame qualification

  // Only counts of 24 or 32 qualify; the count stops at 32, so a longer frame reads as 32 bits and any other length is a cut frame
  always_comb
  begin
    frame_short = 1'b0;
    frame_long = 1'b0;
    case (s_q.bit_cnt)
      `FRAME_BITS:
      begin
        frame_short = 1'b1;
      end
      `FRAME_PEC_BITS:
      begin
        frame_long = 1'b1;
      end
      default:
      begin
        frame_short = 1'b0;
        frame_long = 1'b0;
      end
    endcase
  end
  assign frame_full = frame_short | frame_long;

  // Command word sits in the top 24 bits received; a 32 bit frame carries the check byte last
  assign word_24 = s_q.shift_in;
  assign word_32 = {8'h00, s_q.shift_in[`SHIFT_W-1:`CRC_W]};

  always_comb
  begin
    is_status_read = 1'b0;
    if (frame_short)
    begin
      is_status_read = word_24[`RW_BIT] && (word_24[`ADDR_HI:`ADDR_LO] == `STATUS_READ_ADDR);
    end
    else if (frame_long)
    begin
      is_status_read = word_32[`RW_BIT] && (word_32[`ADDR_HI:`ADDR_LO] == `STATUS_READ_ADDR);
    end
  end

  // A failed check on a full 32 bit frame raises the error
  assign pec_fail = frame_stop && (s_q.phase == PH_SHIFT) && frame_long && !crc_ok;

  // Word counts as read only when the frame that carried it ran to full length
  assign status_consumed = frame_stop && (s_q.phase == PH_SHIFT) && s_q.status_frame && frame_full;

  ////////////////////////////////////////////////////////////////////////////////
  // Packet check

  assign crc_clear = frame_start;
  // Same strobe as the shift register, so the check never sees a bit the frame did not count
  assign crc_bit_valid = take_bit;

  packet_crc packet_crc_i
  (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .clear(crc_clear),
    .bit_valid(crc_bit_valid),
    .bit_in(sdin),
    .crc_ok(crc_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status word

  status_assembler status_assembler_i
  (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .boost_limit(boost_limit),
    .iout_fault_in(iout_fault_in),
    .ramp_active_in(ramp_active_in),
    .over_temp_in(over_temp_in),
    .user_toggle(user_toggle),
    .pec_flag(s_q.pec_flag),
    .status_q(status_q)
  );

  // Pin level is observable but plays no part: each device drives only its own faults
  assign pin_seen_low = ~fault_n_in;

  // Current and temperature faults are live; the packet flag holds until the status is read
  always_comb
  begin
    fault_any = s_q.pec_flag;
    if (|status_q[`IOUT_LSB +: `CHANNELS])
    begin
      fault_any = 1'b1;
    end
    if (status_q[`OTEMP_BIT])
    begin
      fault_any = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial step decode

  // An edge that meets the end of the frame is dropped, so the check and the shift register agree
  always_comb
  begin
    in_frame = (s_q.phase == PH_SHIFT);
    frame_end = 1'b0;
    take_bit = 1'b0;
    emit_bit = 1'b0;
    if (in_frame)
    begin
      if (frame_stop)
      begin
        frame_end = 1'b1;
      end
      else
      begin
        take_bit = sclk_fall && (s_q.bit_cnt < `FRAME_PEC_BITS);
        // Output moves on the rising edge so the host samples a settled bit on the fall
        emit_bit = sclk_rise && (s_q.bit_cnt != '0);
      end
    end
  end

  // Bits past the longest frame are ignored rather than wrapping the count
  always_comb
  begin
    cnt_next = s_q.bit_cnt;
    shift_next = s_q.shift_in;
    out_next = s_q.shift_out;
    if (take_bit)
    begin
      shift_next = {s_q.shift_in[`SHIFT_W-2:0], sdin};
      cnt_next = s_q.bit_cnt + 6'h01;
    end
    if (emit_bit)
    begin
      out_next = {s_q.shift_out[`OUT_W-2:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame contents

  // Snapshot at the frame start; a flag that moves later shows in the next frame
  always_comb
  begin
    status_next_frame = status_on_write_enable || s_q.read_pending;
    out_load = '0;
    if (status_next_frame)
    begin
      out_load = {`OUT_PAD, status_q};
    end
  end

  // Request stands only for the frame after a read; a cut or damaged frame drops it
  always_comb
  begin
    read_next = 1'b0;
    if (frame_full && is_status_read)
    begin
      read_next = !frame_long || crc_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    s_d.sclk = sclk;
    s_d.sync_n = sync_n;
    unique case (s_q.phase)
      PH_IDLE:
      begin
        if (frame_start)
        begin
          s_d.phase = PH_SHIFT;
          s_d.bit_cnt = '0;
          s_d.shift_in = '0;
          // Status goes out on every frame while enabled, else only after a status read
          s_d.status_frame = status_next_frame;
          s_d.shift_out = out_load;
          s_d.sdo = out_load[`OUT_W-1];
        end
      end
      PH_SHIFT:
      begin
        if (frame_end)
        begin
          s_d.phase = PH_IDLE;
          s_d.sdo = 1'b0;
          s_d.status_frame = 1'b0;
          s_d.read_pending = read_next;
        end
        else
        begin
          s_d.bit_cnt = cnt_next;
          s_d.shift_in = shift_next;
          s_d.shift_out = out_next;
          if (emit_bit)
          begin
            s_d.sdo = s_q.shift_out[`OUT_W-2];
          end
        end
      end
    endcase
    // Set wins over the clear so a failure in the reading frame is never lost
    if (pec_fail)
    begin
      s_d.pec_flag = 1'b1;
    end
    else if (status_consumed)
    begin
      s_d.pec_flag = 1'b0;
    end
    s_d.fault_oe = fault_any;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.sclk <= 1'b0;
      s_q.sync_n <= 1'b1;
      s_q.phase <= PH_IDLE;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sdo = s_q.sdo;
  assign fault_n_out = 1'b0;
  assign fault_oe = s_q.fault_oe;
  assign status_word = status_q;
  assign packet_check_error_flag = s_q.pec_flag;

endmodule : fault_status_register

// *** logic/fault_status_cfg.svh ***
// Operation
// - The status word is read-only and no host frame can write any of its flags.
// - With status-on-write enabled, every host frame shifts the status word out on the serial output.
// - With status-on-write clear, a read frame addressing status makes the next frame return the status word.
// - Bits 15 to 12 carry the boost compliance flags of channels D, C, B and A.
// - A channel whose boost converter loses compliance also shows its output-current fault flag.
// - Bit 11 is the user toggle bit, set or cleared through the software register.
// - Bit 10 reports that a received serial word failed its packet check since the status word was last read.
// - Bit 9 is set while any channel is ramping under slew control and clear otherwise.
// - Bit 8 is set while the over-temperature indication is present.
// - Bits 3 to 0 carry the output-current fault flags of channels D, C, B and A.
// - The packet error flag clears once the status word has been read, releasing the fault pin if nothing else holds it.
// - The open-drain fault pin is driven low while any current fault, packet error or over-temperature exists.
// - Status-on-write is off after reset and, while on, no other register is offered for readback.
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Frame layout
`define FRAME_BITS 6'h18
`define FRAME_PEC_BITS 6'h20
`define CNT_W 6
`define SHIFT_W 32
`define OUT_W 24
`define OUT_PAD 8'h00
`define RW_BIT 23
`define ADDR_HI 20
`define ADDR_LO 16
`define STATUS_READ_ADDR 5'h18

////////////////////////////////////////////////////////////////////////////////
// Packet check
`define CRC_W 8
`define CRC_POLY 8'h07
`define CRC_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// Status word fields
`define CHANNELS 4
`define STATUS_W 16
`define STATUS_RESET 16'h0000
`define BOOST_LSB 12
`define TOGGLE_BIT 11
`define PEC_BIT 10
`define RAMP_BIT 9
`define OTEMP_BIT 8
`define UNUSED_LSB 4
`define UNUSED_VAL 4'h0
`define IOUT_LSB 0

`endif

// *** logic/fault_status_pkg.sv ***
package fault_status_pkg;
`include "fault_status_cfg.svh"

  typedef enum logic [0:0]
  {
    PH_IDLE = 1'b0,
    PH_SHIFT = 1'b1
  } phase_t;

  typedef struct packed
  {
    logic sclk;
    logic sync_n;
    phase_t phase;
    logic [`CNT_W-1:0] bit_cnt;
    logic [`SHIFT_W-1:0] shift_in;
    logic [`OUT_W-1:0] shift_out;
    logic sdo;
    logic read_pending;
    logic status_frame;
    logic pec_flag;
    logic fault_oe;
  } top_state_t;

  typedef struct packed
  {
    logic [`CRC_W-1:0] crc;
  } crc_state_t;

  typedef struct packed
  {
    logic [`STATUS_W-1:0] status;
  } status_state_t;

endpackage : fault_status_pkg

// *** logic/packet_crc.sv ***
`timescale 1ns/10ps
`include "fault_status_cfg.svh"

module packet_crc
  import fault_status_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic crc_ok
);

  crc_state_t s_q;
  crc_state_t s_d;
  logic feedback;

  // Data and check byte run through the same divider, so a clean frame leaves zero
  always_comb
  begin
    s_d = s_q;
    feedback = s_q.crc[`CRC_W-1] ^ bit_in;
    if (clear)
    begin
      s_d.crc = `CRC_RESET;
    end
    else if (bit_valid)
    begin
      s_d.crc = {s_q.crc[`CRC_W-2:0], 1'b0} ^ (feedback ? `CRC_POLY : `CRC_RESET);
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign crc_ok = (s_q.crc == `CRC_RESET);

endmodule : packet_crc

// *** logic/status_assembler.sv ***
`timescale 1ns/10ps
`include "fault_status_cfg.svh"

module status_assembler
  import fault_status_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [`CHANNELS-1:0] boost_limit,
  input wire logic [`CHANNELS-1:0] iout_fault_in,
  input wire logic [`CHANNELS-1:0] ramp_active_in,
  input wire logic over_temp_in,
  input wire logic user_toggle,
  input wire logic pec_flag,
  output logic [`STATUS_W-1:0] status_q
);

  status_state_t s_q;
  status_state_t s_d;
  logic [`CHANNELS-1:0] boost_bits;
  logic [`CHANNELS-1:0] iout_bits;

  // Channel A sits in the low bit of each nibble
  genvar ch;
  generate
    for (ch = 0; ch < `CHANNELS; ch = ch + 1)
    begin : g_channel
      assign boost_bits[ch] = boost_limit[ch];
      assign iout_bits[ch] = iout_fault_in[ch] | boost_limit[ch];
    end
  endgenerate

  // Only internal conditions feed the word; nothing from the serial port writes it
  always_comb
  begin
    s_d = s_q;
    s_d.status[`BOOST_LSB +: `CHANNELS] = boost_bits;
    s_d.status[`TOGGLE_BIT] = user_toggle;
    s_d.status[`PEC_BIT] = pec_flag;
    s_d.status[`RAMP_BIT] = |ramp_active_in;
    s_d.status[`OTEMP_BIT] = over_temp_in;
    s_d.status[`UNUSED_LSB +: `CHANNELS] = `UNUSED_VAL;
    s_d.status[`IOUT_LSB +: `CHANNELS] = iout_bits;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign status_q = s_q.status;

endmodule : status_assembler

// *** bench/fault_status_checker.sv ***
`timescale 1ns/10ps
`include "fault_status_cfg.svh"

module fault_status_checker
  import fault_status_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic sdo,
  input wire logic status_on_write_enable,
  input wire logic user_toggle,
  input wire logic [`CHANNELS-1:0] boost_limit,
  input wire logic [`CHANNELS-1:0] iout_fault_in,
  input wire logic [`CHANNELS-1:0] ramp_active_in,
  input wire logic over_temp_in,
  input wire logic fault_n_in,
  input wire logic fault_n_out,
  input wire logic fault_oe,
  input wire logic [`STATUS_W-1:0] status_word,
  input wire logic packet_check_error_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Three idle samples give the design time to see the frame end
  sequence idle3;
    sync_n [*3];
  endsequence
  chk_boost_bits: assert property (status_word[15:12] == $past(boost_limit))
    else $error("boost bits wrong");
  chk_comp_fault: assert property (status_word[3:0] == $past(iout_fault_in | boost_limit))
    else $error("current fault bits wrong");
  chk_toggle_bit: assert property (status_word[11] == $past(user_toggle))
    else $error("toggle bit wrong");
  chk_ramp_bit: assert property (status_word[9] == |$past(ramp_active_in))
    else $error("ramp bit wrong");
  chk_temp_bit: assert property (status_word[8] == $past(over_temp_in))
    else $error("temperature bit wrong");
  chk_unused_zero: assert property (status_word[7:4] == 4'h0)
    else $error("unused bits not zero");
  chk_fault_pin: assert property (fault_oe == $past(|status_word[3:0] | status_word[8] | packet_check_error_flag))
    else $error("fault pin wrong");
  chk_idle_sdo: assert property (idle3 |=> !sdo)
    else $error("serial output busy outside frame");
  chk_pec_set: assert property ($rose(packet_check_error_flag) |-> sync_n)
    else $error("packet error set inside frame");
endmodule : fault_status_checker

bind fault_status_register fault_status_checker fault_status_checker_i (.*);

// *** bench/spi_host_model.sv ***
`timescale 1ns/10ps

module spi_host_model
(
  input wire logic clock,
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input wire logic sdo
);
  // Clock stands low between frames
  initial
  begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b0;
  end

  // Sends nbits of word, MSB first; returns the first 24 bits seen on sdo
  task automatic xfer(input logic [31:0] word, input int nbits, output logic [23:0] rx);
    rx = 24'h00_0000;
    sync_n <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sclk <= 1'b1;
      sdin <= word[i];
      repeat (3) @(posedge clock);
      if (nbits - 1 - i < 24)
        rx = {rx[22:0], sdo};
      sclk <= 1'b0;
      repeat (3) @(posedge clock);
    end
    sync_n <= 1'b1;
    // Released data line: show the inverse, not a stale bit
    sdin <= ~word[0];
    repeat (4) @(posedge clock);
  endtask : xfer
endmodule : spi_host_model

// *** bench/fault_status_register_tb_top.sv ***
`timescale 1ns/10ps
`include "fault_status_cfg.svh"

module fault_status_register_tb_top
  import fault_status_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, sync_n, sdin, sdo, fault_n_out, fault_oe, packet_check_error_flag;
  logic status_on_write_enable = 1'b0;
  logic user_toggle = 1'b0;
  logic over_temp_in = 1'b0;
  logic [3:0] boost_limit = 4'h0;
  logic [3:0] iout_fault_in = 4'h0;
  logic [3:0] ramp_active_in = 4'h0;
  logic [15:0] status_word;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  fault_status_register fault_status_register_i (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
    .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo), .status_on_write_enable(status_on_write_enable),
    .user_toggle(user_toggle), .boost_limit(boost_limit), .iout_fault_in(iout_fault_in),
    .ramp_active_in(ramp_active_in), .over_temp_in(over_temp_in), .fault_n_in(fault_oe ? fault_n_out : 1'b1),
    .fault_n_out(fault_n_out), .fault_oe(fault_oe), .status_word(status_word), .packet_check_error_flag(packet_check_error_flag));

  spi_host_model spi_host_model_i (.clock(clock), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo));

  ////////////////////////////////////////
  function automatic logic [15:0] exp_word(input logic p);
    return {boost_limit, user_toggle, p, |ramp_active_in, over_temp_in, 4'h0, iout_fault_in | boost_limit};
  endfunction : exp_word

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////
  task automatic t_fields();
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clock);
      {boost_limit, iout_fault_in, ramp_active_in, over_temp_in, user_toggle} <= 14'h0001 << i;
      repeat (3) @(posedge clock);
      check(status_word, exp_word(1'b0));
      check(fault_oe, |(iout_fault_in | boost_limit) | over_temp_in);
    end
  endtask : t_fields

  task automatic t_sow();
    logic [23:0] rx;
    @(posedge clock);
    boost_limit <= 4'h9;
    user_toggle <= 1'b1;
    ramp_active_in <= 4'h6;
    status_on_write_enable <= 1'b1;
    repeat (3) @(posedge clock);
    // An all-ones write must not reach any flag
    spi_host_model_i.xfer(32'h00FF_FFFF, 24, rx);
    check(rx, {8'h00, exp_word(1'b0)});
    check(status_word, exp_word(1'b0));
    status_on_write_enable <= 1'b0;
  endtask : t_sow

  task automatic t_pec();
    logic [23:0] rx;
    {boost_limit, iout_fault_in, ramp_active_in, over_temp_in, user_toggle} <= 14'h0000;
    repeat (3) @(posedge clock);
    spi_host_model_i.xfer(32'h0000_0107, 32, rx);
    check(packet_check_error_flag, 1'b0);
    spi_host_model_i.xfer(32'h0000_0100, 32, rx);
    check(packet_check_error_flag, 1'b1);
    check(fault_oe, 1'b1);
    check(fault_n_out, 1'b0);
    spi_host_model_i.xfer(32'h0098_0000, 24, rx);
    check(rx, 24'h00_0000);
    check(packet_check_error_flag, 1'b1);
    spi_host_model_i.xfer(32'h001C_E000, 24, rx);
    check(rx, {8'h00, exp_word(1'b1)});
    check(packet_check_error_flag, 1'b0);
    check(fault_oe, 1'b0);
  endtask : t_pec

  // Checked 32 bit status read, then a cut frame that shows the word but does not count as read
  task automatic t_frames();
    logic [23:0] rx;
    logic [15:0] w;
    w = exp_word(1'b1);
    spi_host_model_i.xfer(32'h0000_0100, 32, rx);
    spi_host_model_i.xfer(32'h9800_00F8, 32, rx);
    check(packet_check_error_flag, 1'b1);
    spi_host_model_i.xfer(32'h001C_E000, 20, rx);
    check(rx, {12'h000, w[15:4]});
    check(packet_check_error_flag, 1'b1);
    spi_host_model_i.xfer(32'h001C_E000, 24, rx);
    check(rx, 24'h00_0000);
  endtask : t_frames

  ////////////////////////////////////////
  // Whole run is about 1600 cycles; the ceiling leaves wide margin
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_fields();
    t_sow();
    t_pec();
    t_frames();
    stop_test();
  end
endmodule : fault_status_register_tb_top
